// >>> tb/test_timer_watchdog_prescaler_irq.sv
// Self-checking bench for the timer, watchdog, prescaler and interrupt block
module test_timer_watchdog_prescaler_irq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] INS_CLR = 4'h8;
  localparam logic [3:0] INS_SLP = 4'h4;
  localparam logic [3:0] INS_RET = 4'h2;
  localparam logic [3:0] INS_SOFT = 4'h1;
  logic clk;
  logic rst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [6:0] opt;
  logic opt_wr;
  logic [3:0] instr;
  logic [5:0] pins;
  logic [7:0] rdata;
  twp_pkg::twp_vector_s vec;
  logic wake;
  logic wdt_rst;
  logic [11:0] last_vec;
  logic [7:0] d;
  int err_count;
  int cmp_count;
  int vec_cnt = 0;
  int wake_cnt = 0;
  int rst_cnt = 0;
  int b;
  logic [5:0] dir;
  int en_m;
  int fl_m;
  int n;
  int f;
  twp_top #(.WDT_TICK_DIV(1)) dut (.I_SYS_CLK(clk), .I_RESET(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_option(opt), .i_option_wr(opt_wr), .i_port_dir_in(dir), .i_startup_cfg(2'h1),
    .i_instr(twp_pkg::twp_instr_s'(instr)), .i_port_pin(pins), .o_rdata(rdata), .o_vector(vec), .o_wake(wake),
    .o_wdt_reset(wdt_rst));
  twp_pin_model pm (.i_clk(clk), .o_pin(pins));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (vec.valid === 1'b1) begin
      vec_cnt <= vec_cnt + 1;
      last_vec <= vec.addr;
    end
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (wdt_rst === 1'b1) rst_cnt <= rst_cnt + 1;
  end
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    if (a == twp_pkg::REG_IRQ_EN) en_m = v;
    if (a == twp_pkg::REG_IRQ_FLAG) fl_m = v & 8'h07;
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    chk(what, {4'h0, d & mask}, {4'h0, exp});
  endtask
  task automatic set_opt(input logic [6:0] v);
    @(posedge clk);
    opt <= v;
    opt_wr <= 1'b1;
    @(posedge clk);
    opt_wr <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    instr <= v;
    @(posedge clk);
    instr <= 4'h0;
  endtask
  task automatic wait_cnt(ref int cnt, input int base, input int lim);
    n = 0;
    while (cnt == base && n < lim) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    {rst, addr, wdata, wr, rd, opt, opt_wr, instr, dir} = {1'b1, 26'h0, 6'h3F};
    {err_count, cmp_count, en_m, fl_m} = '0;
    void'($urandom(32'h242beddb));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk("status_to", twp_pkg::REG_STATUS, 8'h10, 8'h10);
    rd_chk("en_reset", twp_pkg::REG_IRQ_EN, 8'hFF, 8'h78);
    rd_chk("power_reset", twp_pkg::REG_POWER, 8'hFF, 8'hA0);
    rd_chk("unmapped", 4'hA, 8'hFF, 8'h00);
    wr_reg(twp_pkg::REG_POWER, 8'h00);
    // External count, both polarities; five pulses then a final rise
    for (f = 0; f < 2; f++) begin
      set_opt((f == 1) ? 7'h78 : 7'h68);
      pm.drive(2, 1'b0, 4);
      wr_reg(twp_pkg::REG_TIMER, 8'h00);
      repeat (4) @(posedge clk);
      repeat (5) begin
        pm.drive(2, 1'b1, 3);
        pm.drive(2, 1'b0, 3);
      end
      pm.drive(2, 1'b1, 4);
      rd_chk("ext_count", twp_pkg::REG_TIMER, 8'hFF, (f == 1) ? 8'h05 : 8'h06);
    end
    // Flag read is flags AND enables, enables independent of global
    wr_reg(twp_pkg::REG_IRQ_EN, 8'h07);
    wr_reg(twp_pkg::REG_IRQ_FLAG, 8'($urandom));
    rd_chk("flag_and", twp_pkg::REG_IRQ_FLAG, 8'hFF, 8'(fl_m & en_m));
    wr_reg(twp_pkg::REG_IRQ_EN, 8'h05);
    rd_chk("flag_and", twp_pkg::REG_IRQ_FLAG, 8'hFF, 8'(fl_m & en_m));
    rd_chk("en_local", twp_pkg::REG_IRQ_EN, 8'hFF, 8'h7D);
    // Overflow with global set: vector, global dropped, return restores it
    wr_reg(twp_pkg::REG_IRQ_FLAG, 8'h00);
    wr_reg(twp_pkg::REG_TIMER, 8'hFE);
    wr_reg(twp_pkg::REG_IRQ_EN, 8'h81);
    b = vec_cnt;
    set_opt(7'h48);
    wait_cnt(vec_cnt, b, 20);
    chk("ovf_vector", last_vec, twp_pkg::VEC_IRQ);
    rd_chk("gie_clear", twp_pkg::REG_IRQ_EN, 8'hFF, 8'h79);
    wr_reg(twp_pkg::REG_IRQ_FLAG, 8'h00);
    pulse(INS_RET);
    rd_chk("gie_set", twp_pkg::REG_IRQ_EN, 8'hFF, 8'hF9);
    wr_reg(twp_pkg::REG_IRQ_EN, 8'h00);
    set_opt(7'h68);
    b = vec_cnt;
    pulse(INS_SOFT);
    wait_cnt(vec_cnt, b, 20);
    chk("soft_vector", last_vec, twp_pkg::VEC_SOFT);
    // Interrupt pin edges, rising then falling selection
    wr_reg(twp_pkg::REG_POWER, 8'h40);
    wr_reg(twp_pkg::REG_IRQ_EN, 8'h04);
    wr_reg(twp_pkg::REG_IRQ_FLAG, 8'h00);
    pm.drive(0, 1'b1, 4);
    rd_chk("pin_rise", twp_pkg::REG_IRQ_FLAG, 8'hFF, 8'h04);
    set_opt(7'h28);
    wr_reg(twp_pkg::REG_IRQ_FLAG, 8'h00);
    rd_chk("pin_idle", twp_pkg::REG_IRQ_FLAG, 8'hFF, 8'h00);
    pm.drive(0, 1'b0, 4);
    rd_chk("pin_fall", twp_pkg::REG_IRQ_FLAG, 8'hFF, 8'h04);
    // Port change: pin 1 watched, pin 3 unwoken, pin 1 as output excluded, then wake from sleep
    wr_reg(twp_pkg::REG_WAKE, 8'h02);
    rd_chk("port_arm", twp_pkg::REG_PORT, 8'hFF, 8'h04);
    wr_reg(twp_pkg::REG_IRQ_FLAG, 8'h00);
    wr_reg(twp_pkg::REG_IRQ_EN, 8'h02);
    pm.drive(1, 1'b1, 4);
    rd_chk("port_chg", twp_pkg::REG_IRQ_FLAG, 8'hFF, 8'h02);
    rd_chk("port_arm", twp_pkg::REG_PORT, 8'hFF, 8'h06);
    wr_reg(twp_pkg::REG_IRQ_FLAG, 8'h00);
    pm.drive(3, 1'b1, 4);
    rd_chk("port_excl", twp_pkg::REG_IRQ_FLAG, 8'hFF, 8'h00);
    @(posedge clk);
    dir <= 6'h3D;
    pm.drive(1, 1'b0, 4);
    rd_chk("port_dir", twp_pkg::REG_IRQ_FLAG, 8'hFF, 8'h00);
    // Giving pin 1 back to input sees the missed change; clear it before sleeping
    @(posedge clk);
    dir <= 6'h3F;
    wr_reg(twp_pkg::REG_IRQ_FLAG, 8'h00);
    b = wake_cnt;
    pulse(INS_SLP);
    pm.drive(1, 1'b1, 4);
    chk("wake", 12'(wake_cnt - b), 12'h001);
    // Watchdog at 1:1 through the prescaler, cleared, then restarted by sleep
    set_opt(7'h60);
    pulse(INS_CLR);
    wr_reg(twp_pkg::REG_POWER, 8'h80);
    set_opt(7'h68);
    pulse(INS_CLR);
    repeat (2000) @(posedge clk);
    b = rst_cnt;
    pulse(INS_SLP);
    wait_cnt(rst_cnt, b, 6000);
    chk("wdt_period", 12'(n >= 4400 && n <= 4600), 12'h001);
    rd_chk("status_to", twp_pkg::REG_STATUS, 8'h10, 8'h00);
    set_opt(7'h60);
    pulse(INS_CLR);
    wr_reg(twp_pkg::REG_POWER, 8'h00);
    b = rst_cnt;
    repeat (6000) @(posedge clk);
    chk("wdt_off", 12'(rst_cnt - b), 12'h000);
    print_verdict();
  end
endmodule // test_timer_watchdog_prescaler_irq

// >>> tb/twp_pin_model.sv
// Far-side pin model for the port, count and interrupt pins
module twp_pin_model (
  input wire logic i_clk,
  output logic [5:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_pin = 6'h00;
  end
  // Levels last at least three cycles so an unscaled count input meets its high and low minimum
  task automatic drive(input int idx, input logic v, input int hold);
    int h;
    h = (hold < 3) ? 3 : hold;
    @(posedge i_clk);
    o_pin[idx] <= v;
    repeat (h) @(posedge i_clk);
  endtask
endmodule // twp_pin_model

// >>> verilog/twp_pkg.sv
// Package: offsets, field positions, reset values and timing for the timer/watchdog/irq block
package twp_pkg;
  localparam logic [3:0] REG_TIMER = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_PORT = 4'h6;
  localparam logic [3:0] REG_POWER = 4'h8;
  localparam logic [3:0] REG_WAKE = 4'h9;
  localparam logic [3:0] REG_IRQ_EN = 4'hE;
  localparam logic [3:0] REG_IRQ_FLAG = 4'hF;
  localparam int OPT_EDGE_PIN_POL = 6;
  localparam int OPT_SRC_SEL = 5;
  localparam int OPT_CNT_EDGE = 4;
  localparam int OPT_ASSIGN = 3;
  localparam int STATUS_TIMEOUT = 4;
  localparam int POWER_WDT_EN = 7;
  localparam int POWER_EXT_IRQ = 6;
  localparam int IRQ_GLOBAL = 7;
  localparam int IRQ_EDGE = 2;
  localparam int IRQ_PORT = 1;
  localparam int IRQ_OVF = 0;
  localparam logic [6:0] OPTION_RESET = 7'h3F;
  localparam logic [7:0] POWER_RESET = 8'hA0;
  localparam logic [7:0] IRQ_EN_UNUSED = 8'h78;
  localparam logic [7:0] PRESCALE_RESET = 8'hFF;
  localparam logic [11:0] VEC_IRQ = 12'h008;
  localparam logic [11:0] VEC_SOFT = 12'h002;
  localparam int CLK_MHZ = 100;
  localparam int WDT_MS_0 = 18;
  localparam int WDT_US_1 = 4500;
  localparam int WDT_MS_2 = 288;
  localparam int WDT_MS_3 = 72;
  localparam int TIMER_WRITE_HOLD = 2;
  typedef struct packed {
    logic wdt_clear;
    logic sleep;
    logic return_from_irq_instr;
    logic soft_irq;
  } twp_instr_s;
  typedef struct packed {
    logic valid;
    logic [11:0] addr;
  } twp_vector_s;
endpackage

// >>> verilog/twp_prescaler.sv
// Shared 8-bit down-counting prescaler with ratio tap
module twp_prescaler (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic i_timer_side,
  input wire logic [2:0] i_ratio,
  output logic o_out
);
  logic [7:0] cnt_q;
  logic [7:0] used;
  logic [3:0] div;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= twp_pkg::PRESCALE_RESET;
    end else if (i_clear) begin
      cnt_q <= twp_pkg::PRESCALE_RESET;
    end else if (i_tick) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // Timer ratios start at 1:2, watchdog ratios at 1:1
  always_comb begin
    div = {1'b0, i_ratio} + {3'b000, i_timer_side};
    used = 8'hFF >> (4'h8 - div);
  end

  assign o_out = i_tick && ((cnt_q & used) == 8'h00);
endmodule // twp_prescaler

// >>> verilog/twp_top.sv
// Timer/counter, watchdog, shared prescaler and interrupt control
module twp_top #(
  parameter int WDT_TICK_DIV = 100
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [6:0] i_option,
  input wire logic i_option_wr,
  input wire logic [5:0] i_port_dir_in,
  input wire logic [1:0] i_startup_cfg,
  input wire twp_pkg::twp_instr_s i_instr,
  input wire logic [5:0] i_port_pin,
  output logic [7:0] o_rdata,
  output twp_pkg::twp_vector_s o_vector,
  output logic o_wake,
  output logic o_wdt_reset
);
  logic [6:0] option_q;
  logic [7:0] timer_q;
  logic [1:0] hold_q;
  logic [7:0] power_q;
  logic [5:0] wake_q;
  logic [7:0] irq_en_q;
  logic [2:0] flag_q;
  logic timeout_q;
  logic asleep_q;
  logic cnt_pin_q;
  logic int_pin_q;
  logic [5:0] port_q;
  logic [5:0] port_ref_q;
  logic [7:0] rdata_q;
  logic [31:0] wdt_q;
  // A divider of one still needs a one-bit counter, and a zero-width cast is illegal
  localparam int TICK_W = (WDT_TICK_DIV > 1) ? $clog2(WDT_TICK_DIV) : 1;
  logic [TICK_W-1:0] tick_q;
  logic wdt_tick;
  logic timer_write;
  logic to_wdt;
  logic ps_clear;
  logic ps_tick;
  logic ps_out;
  logic cnt_edge;
  logic timer_inc;
  logic timer_ovf;
  logic int_edge;
  logic port_chg;
  logic [5:0] watched;
  logic [2:0] pending;
  logic take_irq;
  logic wdt_expire;
  logic [31:0] wdt_limit;

  function automatic logic [31:0] wdt_base(input logic [1:0] cfg);
    case (cfg)
      2'b00: wdt_base = 32'(twp_pkg::WDT_MS_0 * 1000);
      2'b01: wdt_base = 32'(twp_pkg::WDT_US_1);
      2'b10: wdt_base = 32'(twp_pkg::WDT_MS_2 * 1000);
      default: wdt_base = 32'(twp_pkg::WDT_MS_3 * 1000);
    endcase
  endfunction

  assign to_wdt = option_q[twp_pkg::OPT_ASSIGN];
  assign timer_write = i_wr && (i_addr == twp_pkg::REG_TIMER);
  assign ps_clear = to_wdt ? (i_instr.wdt_clear || i_instr.sleep) : timer_write;
  // Stand-in for the watchdog oscillator: a microsecond tick from the system clock
  assign wdt_tick = (tick_q == '0);
  assign wdt_limit = wdt_base(i_startup_cfg);

  // Sampled pin edge stands in for the T2/T4 synchroniser
  assign cnt_edge = option_q[twp_pkg::OPT_CNT_EDGE] ? (cnt_pin_q && !i_port_pin[2])
                                                     : (!cnt_pin_q && i_port_pin[2]);
  assign ps_tick = to_wdt ? (wdt_tick && power_q[twp_pkg::POWER_WDT_EN])
                          : (option_q[twp_pkg::OPT_SRC_SEL] ? cnt_edge : 1'b1);
  twp_prescaler u_prescaler (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_clear(ps_clear),
    .i_tick(ps_tick),
    .i_timer_side(!to_wdt),
    .i_ratio(option_q[2:0]),
    .o_out(ps_out)
  );

  always_comb begin
    if (to_wdt) begin
      timer_inc = option_q[twp_pkg::OPT_SRC_SEL] ? cnt_edge : 1'b1;
    end else begin
      timer_inc = ps_out;
    end
    timer_inc = timer_inc && (hold_q == 2'b00) && !timer_write;
  end
  assign timer_ovf = timer_inc && (timer_q == 8'hFF);

  assign int_edge = option_q[twp_pkg::OPT_EDGE_PIN_POL] ? (!int_pin_q && i_port_pin[0])
                                                         : (int_pin_q && !i_port_pin[0]);
  assign watched = wake_q & i_port_dir_in & {5'b11111, !power_q[twp_pkg::POWER_EXT_IRQ]};
  assign port_chg = |((i_port_pin ^ port_ref_q) & watched) && irq_en_q[twp_pkg::IRQ_PORT];
  assign pending = flag_q & irq_en_q[2:0];
  // Held off during a soft interrupt so the global clear never lands without its vector
  assign take_irq = irq_en_q[twp_pkg::IRQ_GLOBAL] && (|pending) && !o_vector.valid
                    && !i_instr.soft_irq;

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      option_q <= twp_pkg::OPTION_RESET;
    end else if (i_option_wr) begin
      option_q <= i_option;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      timer_q <= 8'h00;
      hold_q <= 2'b00;
    end else if (timer_write) begin
      timer_q <= i_wdata;
      hold_q <= 2'(twp_pkg::TIMER_WRITE_HOLD);
    end else begin
      if (hold_q != 2'b00) begin
        hold_q <= hold_q - 2'b01;
      end
      if (timer_inc) begin
        timer_q <= timer_q + 8'h01;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cnt_pin_q <= 1'b0;
      int_pin_q <= 1'b0;
      port_q <= 6'h00;
    end else begin
      cnt_pin_q <= i_port_pin[2];
      int_pin_q <= i_port_pin[0];
      port_q <= i_port_pin;
    end
  end

  // Port access re-arms the change reference, so software must touch the port first
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      port_ref_q <= 6'h00;
    end else if ((i_rd || i_wr) && i_addr == twp_pkg::REG_PORT) begin
      port_ref_q <= i_port_pin;
    end else if (port_chg) begin
      port_ref_q <= i_port_pin;
    end
  end

  // Set wins over a same-cycle software clear
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      flag_q <= 3'b000;
    end else begin
      if (i_wr && i_addr == twp_pkg::REG_IRQ_FLAG) begin
        flag_q <= i_wdata[2:0];
      end
      if (timer_ovf) begin
        flag_q[twp_pkg::IRQ_OVF] <= 1'b1;
      end
      if (port_chg) begin
        flag_q[twp_pkg::IRQ_PORT] <= 1'b1;
      end
      if (int_edge) begin
        flag_q[twp_pkg::IRQ_EDGE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      irq_en_q <= 8'h00;
    end else if (take_irq) begin
      irq_en_q[twp_pkg::IRQ_GLOBAL] <= 1'b0;
    end else if (i_instr.return_from_irq_instr) begin
      irq_en_q[twp_pkg::IRQ_GLOBAL] <= 1'b1;
    end else if (i_wr && i_addr == twp_pkg::REG_IRQ_EN) begin
      irq_en_q <= {i_wdata[7], 4'h0, i_wdata[2:0]};
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      power_q <= twp_pkg::POWER_RESET;
      wake_q <= 6'h00;
    end else if (i_wr && i_addr == twp_pkg::REG_POWER) begin
      power_q <= {i_wdata[7:5], 5'h00};
    end else if (i_wr && i_addr == twp_pkg::REG_WAKE) begin
      wake_q <= i_wdata[5:0];
    end
  end

  // Sleep and wake; the wake pulse vectors only when the global enable is set
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      asleep_q <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_wake <= 1'b0;
      if (i_instr.sleep) begin
        asleep_q <= 1'b1;
      end else if (asleep_q && ((int_edge && irq_en_q[twp_pkg::IRQ_EDGE]) || port_chg)) begin
        asleep_q <= 1'b0;
        o_wake <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_vector <= '0;
    end else if (i_instr.soft_irq) begin
      o_vector <= '{valid: 1'b1, addr: twp_pkg::VEC_SOFT};
    end else if (take_irq) begin
      o_vector <= '{valid: 1'b1, addr: twp_pkg::VEC_IRQ};
    end else begin
      o_vector <= '0;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      tick_q <= '0;
    end else if (tick_q == TICK_W'(WDT_TICK_DIV - 1)) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  // Watchdog counts whether or not the core sleeps
  assign wdt_expire = power_q[twp_pkg::POWER_WDT_EN] && (wdt_q >= wdt_limit);
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      wdt_q <= 32'h0000_0000;
    end else if (i_instr.wdt_clear || i_instr.sleep || wdt_expire) begin
      wdt_q <= 32'h0000_0000;
    end else if (power_q[twp_pkg::POWER_WDT_EN] && wdt_tick && (!to_wdt || ps_out)) begin
      wdt_q <= wdt_q + 32'h0000_0001;
    end
  end

  // Timeout bit is set by reset, clear or sleep and dropped by expiry, so software can see why it restarted
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_wdt_reset <= 1'b0;
      timeout_q <= 1'b1;
    end else begin
      o_wdt_reset <= wdt_expire;
      if (wdt_expire) begin
        timeout_q <= 1'b0;
      end else if (i_instr.wdt_clear || i_instr.sleep) begin
        timeout_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        twp_pkg::REG_TIMER: rdata_q <= timer_q;
        twp_pkg::REG_STATUS: rdata_q <= {3'b000, timeout_q, 4'h0};
        twp_pkg::REG_PORT: rdata_q <= {2'b00, port_q};
        twp_pkg::REG_POWER: rdata_q <= power_q;
        twp_pkg::REG_WAKE: rdata_q <= {2'b00, wake_q};
        twp_pkg::REG_IRQ_EN: rdata_q <= irq_en_q | twp_pkg::IRQ_EN_UNUSED;
        twp_pkg::REG_IRQ_FLAG: rdata_q <= {5'h00, pending};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign o_rdata = rdata_q;

  gie_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    take_irq && !i_instr.soft_irq |=> !irq_en_q[7] && o_vector.valid && o_vector.addr == 12'h008)
    else $error("irq entry did not vector");
  return_from_irq_instr_set_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    i_instr.return_from_irq_instr && !take_irq |=> irq_en_q[7])
    else $error("return did not restore enable");
  soft_vec_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    i_instr.soft_irq |=> o_vector.addr == 12'h002)
    else $error("soft irq vector wrong");
  ovf_flag_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    timer_inc && timer_q == 8'hFF && !timer_write |=> timer_q == 8'h00 && flag_q[0])
    else $error("rollover flag missing");
  write_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    timer_write ##1 !timer_write [*3] |-> timer_q == $past(timer_q, 2))
    else $error("timer moved after write");
  edge_flag_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    int_edge |=> flag_q[2])
    else $error("edge flag missing");
  flag_read_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    i_rd && i_addr == 4'hF |=> o_rdata == {5'h00, $past(flag_q) & $past(irq_en_q[2:0])})
    else $error("flag read not masked");
  wdt_off_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    !power_q[7] |=> !o_wdt_reset)
    else $error("disabled watchdog fired");
  timeout_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    wdt_expire |=> o_wdt_reset && !timeout_q)
    else $error("expiry not reported");
  sleep_wdt_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    i_instr.sleep |=> wdt_q == 32'h0000_0000)
    else $error("sleep did not restart watchdog");
  ps_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (to_wdt ? i_instr.wdt_clear : timer_write) |=> u_prescaler.cnt_q == 8'hFF)
    else $error("prescaler not cleared");
  port_mask_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    !flag_q[1] && !(i_wr && i_addr == 4'hF) && ((i_port_pin ^ port_ref_q) & wake_q & i_port_dir_in) == 6'h00
    |=> !flag_q[1]) else $error("excluded pin raised change flag");
  wake_pulse_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    asleep_q && !i_instr.sleep && port_chg |=> o_wake && !asleep_q)
    else $error("port change did not wake");
endmodule // twp_top
